// ---- rtl/sss_top.sv ----
`timescale 1ns/1ps
// Contract
// R1: Only synchronous slave mode shifts in sleep; other modes stop.
// R2: Shift registers advance on the externally driven shift clock.
// R3: Software configures slave receive and drains receive data before sleep.
// R4: Software sets receive, peripheral and global enables for wake.
// R5: Full received word sets receive_done_flag, which wakes the core.
// R6: Core resumes after sleep; with global enable it calls 004h.
// R7: Software configures slave transmit and fills both transmit stages.
// R8: Software sets transmit and peripheral enables before sleep.
// R9: Emptied shift register takes holding byte, sets transmit_space_flag, wakes.
// R10: Holding register accepts a new byte; writing clears transmit_space_flag.
// R11: Slave select: sync set, clock master clear, port enable set.
// R12: Overrun holds until continuous receive or port enable is cleared.
// R13: Flags stay set after wake until software clears them.
module sss_top #(
  parameter int WORD_BITS = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire sss_pkg::sss_bus_req_t BUS_I,
  output logic [sss_pkg::DATA_W-1:0] RDATA_O,
  input wire logic SCK_I,
  input wire logic DT_I,
  output logic DT_O,
  output logic DT_OE_O,
  input wire logic SLEEP_I,
  output logic IRQ_O,
  output logic WAKE_O,
  output logic CALL_O,
  output logic [sss_pkg::VEC_W-1:0] VECTOR_O
);
  import sss_pkg::*;

  localparam int CNT_W = $clog2(WORD_BITS);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WORD_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // ==========================================================
  // State
  typedef struct packed {
    logic [DATA_W-1:0] tx_ctrl;
    logic [DATA_W-1:0] rx_ctrl;
    logic [DATA_W-1:0] baud;
    logic [DATA_W-1:0] irq_en;
    logic [DATA_W-1:0] int_ctrl;
    logic [DATA_W-1:0] thr;
    logic thr_full;
    logic [DATA_W-1:0] transmit_shift_register;
    logic tsr_full;
    logic [CNT_W-1:0] tcnt;
    logic [DATA_W-1:0] rsr;
    logic [CNT_W-1:0] rcnt;
    logic [DATA_W-1:0] rhr;
    logic rx_done;
    logic ovr;
    logic sck_prev;
    logic dt_out;
    logic dt_oe;
    logic [DATA_W-1:0] rdata;
    logic wake;
    logic call;
    logic [VEC_W-1:0] vec;
  } sss_state_t;

  sss_state_t q;
  sss_state_t d;

  // ==========================================================
  // Pin synchronisers
  sss_link_t link_raw;
  sss_link_t link_s;

  assign link_raw.sck = SCK_I;
  assign link_raw.dt = DT_I;

  // Both link pins come from the far party's clock domain
  sss_sync #(
    .W($bits(sss_link_t))
  ) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .d_i(link_raw),
    .q_o(link_s)
  );

  // ==========================================================
  // Event status and mask
  logic [EV_N-1:0] events;
  logic [EV_N-1:0] ev_status;
  logic [EV_N-1:0] ev_mask;
  logic ev_stat_wr;
  logic ev_mask_wr;
  logic irq_line;

  // Event registers decode their own writes
  assign ev_stat_wr = BUS_I.wr && (BUS_I.addr == OFF_EV_STAT);
  assign ev_mask_wr = BUS_I.wr && (BUS_I.addr == OFF_EV_MASK);

  sss_irq #(
    .N(EV_N)
  ) u_irq (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .event_i(events),
    .stat_wr_i(ev_stat_wr),
    .mask_wr_i(ev_mask_wr),
    .wdata_i(BUS_I.wdata[EV_N-1:0]),
    .status_o(ev_status),
    .mask_o(ev_mask),
    .irq_o(irq_line)
  );

  // ==========================================================
  // Mode decode
  logic port_en;
  logic slave_mode;
  logic tx_mode;
  logic rx_mode;
  logic sck_now;
  logic sck_rise;
  logic sck_fall;

  // Polarity bit folds into the clock before edge detection
  always_comb begin
    port_en = q.rx_ctrl[RX_PORT_EN];
    // R11: slave selection
    slave_mode = port_en && q.tx_ctrl[TX_SYNC]
      && !q.tx_ctrl[TX_CLK_MASTER];
    // R1: only slave shifts
    tx_mode = slave_mode && q.tx_ctrl[TX_ENABLE]
      && !q.rx_ctrl[RX_CONT_EN] && !q.rx_ctrl[RX_SINGLE_EN];
    rx_mode = slave_mode && q.rx_ctrl[RX_CONT_EN];
    sck_now = link_s.sck ^ q.baud[BAUD_CLK_POL];
    sck_rise = sck_now && !q.sck_prev;
    sck_fall = !sck_now && q.sck_prev;
  end

  // ==========================================================
  // Read mux
  logic [DATA_W-1:0] rd_val;

  // Status bits are merged into the stored control bytes
  always_comb begin
    rd_val = '0;
    case (BUS_I.addr)
      OFF_TX_CTRL: begin
        rd_val = q.tx_ctrl;
        rd_val[TX_SHIFT_EMPTY] = !q.tsr_full;
      end
      OFF_RX_CTRL: begin
        rd_val = q.rx_ctrl;
        rd_val[RX_OVERRUN] = q.ovr;
      end
      OFF_BAUD: begin
        rd_val = q.baud;
        rd_val[BAUD_RX_IDLE] = (q.rcnt == '0);
      end
      OFF_RX_DATA: begin
        rd_val = q.rhr;
      end
      OFF_FLAGS: begin
        rd_val[FLAG_RX_DONE] = q.rx_done;
        rd_val[FLAG_TX_SPACE] = !q.thr_full;
      end
      OFF_IRQ_EN: begin
        rd_val = q.irq_en;
      end
      OFF_INT_CTRL: begin
        rd_val = q.int_ctrl;
      end
      OFF_EV_STAT: begin
        rd_val[EV_N-1:0] = ev_status;
      end
      OFF_EV_MASK: begin
        rd_val[EV_N-1:0] = ev_mask;
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  // ==========================================================
  // Next state
  logic pend;

  always_comb begin
    d = q;
    events = '0;
    pend = 1'b0;
    d.sck_prev = sck_now;

    // Software writes; clears come before hardware sets
    if (BUS_I.wr) begin
      case (BUS_I.addr)
        OFF_TX_CTRL: begin
          d.tx_ctrl = BUS_I.wdata & TX_CTRL_WMASK;
        end
        OFF_RX_CTRL: begin
          d.rx_ctrl = BUS_I.wdata & RX_CTRL_WMASK;
        end
        OFF_BAUD: begin
          d.baud = BUS_I.wdata & BAUD_WMASK;
        end
        OFF_TX_DATA: begin
          // R10: write clears space
          d.thr = BUS_I.wdata;
          d.thr_full = 1'b1;
        end
        OFF_IRQ_EN: begin
          d.irq_en = BUS_I.wdata & IRQ_EN_WMASK;
        end
        OFF_INT_CTRL: begin
          d.int_ctrl = BUS_I.wdata & INT_CTRL_WMASK;
        end
        default: begin
          d.thr_full = q.thr_full;
        end
      endcase
    end

    // R13: read clears done
    if (BUS_I.rd && BUS_I.addr == OFF_RX_DATA) begin
      d.rx_done = 1'b0;
    end

    // Read data stand for exactly one cycle
    d.rdata = BUS_I.rd ? rd_val : '0;

    // R2: transmit on link edges
    if (tx_mode && q.tsr_full) begin
      if (sck_rise) begin
        d.transmit_shift_register = q.transmit_shift_register >> 1;
        d.tcnt = q.tcnt + CNT_ONE;
        if (q.tcnt == CNT_LAST) begin
          d.tsr_full = 1'b0;
        end
      end
      if (sck_fall) begin
        d.dt_out = q.transmit_shift_register[0];
      end
    end

    // R9: holding byte moves on
    if (tx_mode && !d.tsr_full && d.thr_full) begin
      d.transmit_shift_register = d.thr;
      d.tsr_full = 1'b1;
      d.thr_full = 1'b0;
      d.tcnt = '0;
      d.dt_out = d.thr[0];
      events[EV_TX_LOAD] = 1'b1;
    end
    d.dt_oe = tx_mode;

    // R5: receive on link edges
    if (rx_mode && !q.ovr && sck_rise) begin
      d.rsr = {link_s.dt, q.rsr[DATA_W-1:1]};
      d.rcnt = q.rcnt + CNT_ONE;
      if (q.rcnt == CNT_LAST) begin
        d.rcnt = '0;
        if (d.rx_done) begin
          // R12: overrun holds
          d.ovr = 1'b1;
          events[EV_OVERRUN] = 1'b1;
        end else begin
          d.rhr = {link_s.dt, q.rsr[DATA_W-1:1]};
          d.rx_done = 1'b1;
          events[EV_RX_WORD] = 1'b1;
        end
      end
    end

    // R12: receive enable off clears
    if (!q.rx_ctrl[RX_CONT_EN]) begin
      d.ovr = 1'b0;
      d.rcnt = '0;
    end

    // R12: port off clears stage fills, counts, done, overrun and data out
    if (!port_en) begin
      d.thr_full = 1'b0;
      d.tsr_full = 1'b0;
      d.tcnt = '0;
      d.rcnt = '0;
      d.rx_done = 1'b0;
      d.ovr = 1'b0;
      d.dt_out = 1'b0;
    end

    // R9: space wakes only through both enables
    pend = d.int_ctrl[INT_PERIPH] && (
      (d.rx_done && d.irq_en[FLAG_RX_DONE]) ||
      (!d.thr_full && port_en && d.irq_en[FLAG_TX_SPACE]));

    // R6: wake and vector call in the same cycle
    d.wake = SLEEP_I && pend;
    d.call = pend && d.int_ctrl[INT_GLOBAL];
    d.vec = ISR_ADDR;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      q <= '0;
      q.tx_ctrl <= CTRL_RESET;
      q.rx_ctrl <= CTRL_RESET;
      q.vec <= ISR_ADDR;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign RDATA_O = q.rdata;
  assign DT_O = q.dt_out;
  assign DT_OE_O = q.dt_oe;
  assign IRQ_O = irq_line;
  assign WAKE_O = q.wake;
  assign CALL_O = q.call;
  assign VECTOR_O = q.vec;

endmodule

// ---- rtl/sss_pkg.sv ----
package sss_pkg;

  // ==========================================================
  // Bus and data widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int VEC_W = 12;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_TX_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_RX_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_BAUD = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_RX_DATA = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_TX_DATA = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_INT_CTRL = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_EV_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_EV_MASK = 4'h9;

  // ==========================================================
  // Field positions
  localparam int TX_CLK_MASTER = 7;
  localparam int TX_ENABLE = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_SHIFT_EMPTY = 1;
  localparam int RX_PORT_EN = 7;
  localparam int RX_SINGLE_EN = 5;
  localparam int RX_CONT_EN = 4;
  localparam int RX_OVERRUN = 1;
  localparam int BAUD_RX_IDLE = 6;
  localparam int BAUD_CLK_POL = 4;
  localparam int FLAG_RX_DONE = 5;
  localparam int FLAG_TX_SPACE = 4;
  localparam int INT_GLOBAL = 7;
  localparam int INT_PERIPH = 6;

  // Writable bits of each control register
  localparam logic [DATA_W-1:0] TX_CTRL_WMASK = 8'hb0;
  localparam logic [DATA_W-1:0] RX_CTRL_WMASK = 8'hb0;
  localparam logic [DATA_W-1:0] BAUD_WMASK = 8'h10;
  localparam logic [DATA_W-1:0] IRQ_EN_WMASK = 8'h30;
  localparam logic [DATA_W-1:0] INT_CTRL_WMASK = 8'hc0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

  // Service routine entry handed to the core
  localparam logic [VEC_W-1:0] ISR_ADDR = 12'h004;

  // ==========================================================
  // Event status bits
  localparam int EV_RX_WORD = 0;
  localparam int EV_TX_LOAD = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_N = 3;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sss_bus_req_t;

  typedef struct packed {
    logic sck;
    logic dt;
  } sss_link_t;

endpackage

// ---- rtl/sss_sync.sv ----
`timescale 1ns/1ps
module sss_sync #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sss_sync_st_t;

  sss_sync_st_t q;
  sss_sync_st_t d;

  // First stage feeds the second stage only
  always_comb begin
    d = q;
    d.s1 = d_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_o = q.s2;

endmodule

// ---- rtl/sss_irq.sv ----
`timescale 1ns/1ps
module sss_irq #(
  parameter int N = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] event_i,
  input wire logic stat_wr_i,
  input wire logic mask_wr_i,
  input wire logic [N-1:0] wdata_i,
  output logic [N-1:0] status_o,
  output logic [N-1:0] mask_o,
  output logic irq_o
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic irq;
  } sss_irq_st_t;

  sss_irq_st_t q;
  sss_irq_st_t d;

  // Write one clears; a new event in the same cycle wins
  always_comb begin
    d = q;
    if (stat_wr_i) begin
      d.status = q.status & ~wdata_i;
    end
    d.status = d.status | event_i;
    if (mask_wr_i) begin
      d.mask = wdata_i;
    end
    d.irq = |(d.status & d.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign status_o = q.status;
  assign mask_o = q.mask;
  assign irq_o = q.irq;

endmodule

// ---- testbench/sss_ext_master.sv ----
`timescale 1ns/1ps
// ==========================================================
// External synchronous master that owns the shift clock
module sss_ext_master (
  input wire logic data_i,
  output logic sck_o,
  output logic dt_o
);
  // Clock stands low between frames
  initial begin
    sck_o = 1'b0;
    dt_o = 1'b1;
  end

  // external shift clock
  // LSB first; the slave samples and shifts on rise and drives its data pin on fall
  // Pins move by non-blocking assignment so the block's clock edge that
  // coincides with a pin change always sees the old value
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      dt_o <= tx[i];
      #40 sck_o <= 1'b1;
      rx[i] = data_i;
      #40 sck_o <= 1'b0;
    end
    // Released line shows the inverse so stale data never matches
    dt_o <= ~tx[7];
  endtask
endmodule

// ---- testbench/sss_sva.sv ----
`timescale 1ns/1ps
module sss_sva
  import sss_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire sss_pkg::sss_bus_req_t BUS_I,
  input wire logic [sss_pkg::DATA_W-1:0] RDATA_O,
  input wire logic SCK_I,
  input wire logic DT_O,
  input wire logic DT_OE_O,
  input wire logic SLEEP_I,
  input wire logic IRQ_O,
  input wire logic WAKE_O,
  input wire logic [sss_pkg::VEC_W-1:0] VECTOR_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  logic [2:0] acc_q;

  // ==========================================================
  // Bus activity of the last three cycles, for causes of change
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      acc_q <= 3'h0;
    end else begin
      acc_q <= {acc_q[1:0], BUS_I.wr | BUS_I.rd};
    end
  end

  // Clock held high long enough for any edge effect to settle
  sequence sck_high_run;
    (SCK_I && !BUS_I.wr)[*7];
  endsequence

  // ==========================================================
  // Properties
  a_vector_fixed: assert property (VECTOR_O == ISR_ADDR)
    else $error("service vector moved");
  a_rdata_idle: assert property (!$past(BUS_I.rd) |-> RDATA_O == 8'h00)
    else $error("read data outside its cycle");
  a_rdata_unmapped: assert property ($past(BUS_I.rd)
    && $past(BUS_I.addr) > OFF_EV_MASK |-> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_oe_write: assert property ($changed(DT_OE_O) |-> |acc_q)
    else $error("drive enable changed without a write");
  a_dt_steady: assert property (sck_high_run |=> $stable(DT_O))
    else $error("data pin moved without a clock edge");
  a_wake_sleep: assert property (WAKE_O |-> $past(SLEEP_I))
    else $error("wake while not asleep");
  a_wake_hold: assert property ($fell(WAKE_O) |->
    !$past(SLEEP_I) || |acc_q)
    else $error("wake dropped on its own");
  a_irq_fall: assert property ($fell(IRQ_O) |-> |acc_q)
    else $error("interrupt dropped on its own");
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
// ==========================================================
// Checker attachment
bind sss_top sss_sva sss_sva_i (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
  .BUS_I(BUS_I), .RDATA_O(RDATA_O), .SCK_I(SCK_I), .DT_O(DT_O),
  .DT_OE_O(DT_OE_O), .SLEEP_I(SLEEP_I), .IRQ_O(IRQ_O), .WAKE_O(WAKE_O),
  .VECTOR_O(VECTOR_O));

module testbench;
  import sss_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sss_bus_req_t bus = '0;
  logic sleep = 1'b0;
  logic sck, mdt, dt_o, dt_oe, irq, wake, call;
  logic [DATA_W-1:0] rdata, d;
  logic [VEC_W-1:0] vec;
  logic [31:0] seed = 32'ha4908dfa;
  int miscompares = 0;
  int check_count = 0;
  int ovr = 0;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  // Shared data pin: the device wins while it drives
  wire logic pin = dt_oe ? dt_o : mdt;

  always #2.5 clk = ~clk;

  sss_top sss_top_i (.SYS_CLK_I(clk), .RESET_I(rst), .BUS_I(bus),
    .RDATA_O(rdata), .SCK_I(sck), .DT_I(pin), .DT_O(dt_o), .DT_OE_O(dt_oe),
    .SLEEP_I(sleep), .IRQ_O(irq), .WAKE_O(wake), .CALL_O(call),
    .VECTOR_O(vec));
  sss_ext_master sss_ext_master_i (.data_i(pin), .sck_o(sck), .dt_o(mdt));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bus cycles: one strobe cycle, data sampled the cycle after a read
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask

  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 chk(n, e, rdata);
  endtask

  task automatic wait_wake();
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 400) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  // Model: one-deep receive holding, a second word is an overrun
  task automatic send();
    logic [7:0] t;
    t = rnd();
    if (rxq.size() > 0) ovr = 1;
    else rxq.push_back(t);
    sss_ext_master_i.frame(t, d);
  endtask

  task automatic load();
    txq.push_back(rnd());
    wr(OFF_TX_DATA, txq[$]);
  endtask

  task automatic take();
    sss_ext_master_i.frame(8'h00, d);
    chk("tx word", txq.pop_front(), d);
  endtask

  // Hang guard
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rchk("flags", OFF_FLAGS, 8'h10);
    rchk("unmapped", 4'hc, 8'h00);
    chk("vector", ISR_ADDR, vec);
    // Slave receive set-up, drained, then asleep
    wr(OFF_TX_CTRL, 8'h10);
    wr(OFF_RX_CTRL, 8'h90);
    wr(OFF_IRQ_EN, 8'h20);
    wr(OFF_INT_CTRL, 8'hc0);
    wr(OFF_EV_MASK, 8'h07);
    rchk("rx drain", OFF_RX_DATA, 8'h00);
    @(posedge clk) sleep <= 1'b1;
    send();
    wait_wake();
    chk("call", 1'b1, call);
    chk("irq", 1'b1, irq);
    @(posedge clk) sleep <= 1'b0;
    rchk("flags", OFF_FLAGS, 8'h30);
    rchk("rx data", OFF_RX_DATA, rxq.pop_front());
    rchk("flags", OFF_FLAGS, 8'h10);
    rchk("events", OFF_EV_STAT, 8'h01);
    wr(OFF_EV_STAT, 8'h01);
    rchk("events", OFF_EV_STAT, 8'h00);
    chk("irq", 1'b0, irq);
    // Two words with no read between them
    send();
    send();
    rchk("rx ctrl", OFF_RX_CTRL, ovr ? 8'h92 : 8'h90);
    wr(OFF_RX_CTRL, 8'h80);
    rchk("rx ctrl", OFF_RX_CTRL, 8'h80);
    rchk("rx data", OFF_RX_DATA, rxq.pop_front());
    wr(OFF_EV_STAT, 8'h07);
    // Master-clocked mode must not shift
    wr(OFF_TX_CTRL, 8'h90);
    wr(OFF_RX_CTRL, 8'h90);
    // Inverted clock sense gives a false edge that must not shift here
    wr(OFF_BAUD, 8'h10);
    rchk("baud", OFF_BAUD, 8'h50);
    wr(OFF_BAUD, 8'h00);
    sss_ext_master_i.frame(rnd(), d);
    rchk("flags", OFF_FLAGS, 8'h10);
    chk("irq", 1'b0, irq);
    // Slave transmit with both stages filled before sleep
    wr(OFF_RX_CTRL, 8'h80);
    wr(OFF_TX_CTRL, 8'h30);
    wr(OFF_IRQ_EN, 8'h10);
    wr(OFF_INT_CTRL, 8'h40);
    load();
    load();
    rchk("flags", OFF_FLAGS, 8'h00);
    rchk("tx ctrl", OFF_TX_CTRL, 8'h30);
    chk("drive", 1'b1, dt_oe);
    @(posedge clk) sleep <= 1'b1;
    take();
    wait_wake();
    chk("call", 1'b0, call);
    @(posedge clk) sleep <= 1'b0;
    rchk("flags", OFF_FLAGS, 8'h10);
    load();
    rchk("flags", OFF_FLAGS, 8'h00);
    take();
    take();
    rchk("tx ctrl", OFF_TX_CTRL, 8'h32);
    tally_and_finish();
  end
endmodule
